/* File: core/rcr_regs.svh */
// Constants of the register file and execution core
`ifndef RCR_REGS_SVH
`define RCR_REGS_SVH

// ****************************************
// Sizes
// ****************************************
`define RCR_NREG       32
`define RCR_PC_W       9
`define RCR_STK_DEPTH  3
`define RCR_NIRQ       4

// ****************************************
// Addresses and reset values
// ****************************************
`define RCR_IO_STATUS  6'h3f
`define RCR_PTR_IDX    5'h1e
`define RCR_UPPER_OFS  5'h10
`define RCR_RESET_PC   9'h000
`define RCR_STATUS_RST 8'h00
`define RCR_RC_FREQ_HZ 1000000

// ****************************************
// Status register bit positions
// ****************************************
`define RCR_BIT_I      7
`define RCR_BIT_V      3
`define RCR_BIT_N      2
`define RCR_BIT_Z      1
`define RCR_BIT_C      0

`endif

/* File: core/rcr_pkg.sv */
// Types of the register file and execution core
package rcr_pkg;

  typedef enum logic [4:0] {
    OP_NOP           = 5'b00000,
    OP_ADD           = 5'b00001,
    OP_ADC           = 5'b00010,
    OP_SUB           = 5'b00011,
    OP_SBC           = 5'b00100,
    OP_CP            = 5'b00101,
    OP_AND           = 5'b00110,
    OP_OR            = 5'b00111,
    OP_EOR           = 5'b01000,
    OP_MOV           = 5'b01001,
    OP_SUB_IMM       = 5'b01010,
    OP_SUB_CARRY_IMM = 5'b01011,
    OP_CMP_IMM       = 5'b01100,
    OP_AND_IMM       = 5'b01101,
    OP_OR_IMM        = 5'b01110,
    OP_LOAD_IMM      = 5'b01111,
    OP_COM           = 5'b10000,
    OP_NEG           = 5'b10001,
    OP_INC           = 5'b10010,
    OP_DEC           = 5'b10011,
    OP_LSR           = 5'b10100,
    OP_REL_JUMP      = 5'b10101,
    OP_REL_CALL      = 5'b10110,
    OP_RET           = 5'b10111,
    OP_RET_INT       = 5'b11000,
    OP_SLEEP         = 5'b11001,
    OP_SEI           = 5'b11010,
    OP_CLI           = 5'b11011,
    OP_IN            = 5'b11100,
    OP_OUT           = 5'b11101,
    OP_LD_PTR        = 5'b11110,
    OP_ST_PTR        = 5'b11111
  } rcr_op_e;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_IDLE  = 2'b01,
    ST_PDOWN = 2'b10
  } rcr_state_e;

  typedef struct packed {
    logic       we;
    logic [5:0] addr;
    logic [7:0] data;
  } rcr_io_wr_s;

  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       z;
    logic       n;
    logic       v;
  } rcr_alu_s;

endpackage : rcr_pkg

/* File: core/rcr_core.sv */
// Register file, pipeline, hardware stack, interrupts and sleep of the 8-bit core
//
// Contract
// - 32 registers of 8 bits; two reads, one ALU op, one write per cycle.
// - ALU works register-register, register-immediate and single-register.
// - Immediate ops and load-immediate reach only the upper sixteen registers.
// - Register-register and single-register ops reach all 32 registers.
// - Register 30 is an 8-bit pointer for indirect register access.
// - Two-stage pipeline prefetches next word while current one executes.
// - Every instruction is one 16-bit word at one program address.
// - Relative jump and call reach all 512 program words.
// - Calls and interrupts save return address in a three-level hardware stack.
// - Each interrupt source has its own vector at program memory start.
// - Among pending interrupts, the lowest vector address is served first.
// - Interrupts gated by global enable bit plus per-source enables outside.
// - The core reaches an I/O space of 64 locations.
// - Idle sleep halts execution; registers and interrupt logic keep running.
// - Power-down keeps registers, stops oscillator until external interrupt or reset.
// - Clock-select fuse at 0 picks the 1 MHz RC oscillator, else crystal.
// - Push into level 0 shifting deeper; pop from level 0 shifting up.
// - Beyond three nested levels the oldest address is silently lost.
// - Relative target is current address plus signed offset plus one.
// - Taking an interrupt clears global enable; return-from-interrupt sets it.
`timescale 1ns/1ps
`include "rcr_regs.svh"

module rcr_core
  import rcr_pkg::*;
(
  input  wire logic                     CORE_CLK,
  input  wire logic                     NRST,
  output      logic [`RCR_PC_W-1:0]     PROG_ADDR,
  input  wire logic [15:0]              PROG_DATA,
  output      logic [5:0]               IO_RD_ADDR,
  output      logic                     IO_RE,
  input  wire logic [7:0]               IO_RDATA,
  output      rcr_io_wr_s               IO_WR,
  input  wire logic [`RCR_NIRQ-1:0]     IRQ_PEND,
  output      logic [`RCR_NIRQ-1:0]     IRQ_ACK,
  input  wire logic                     EXT_WAKE,
  input  wire logic                     SLEEP_EN,
  input  wire logic                     SLEEP_PDOWN,
  input  wire logic                     RC_CLOCK_SELECT_FUSE,
  output      logic                     RC_CLK_SEL,
  output      logic                     OSC_STOP,
  output      logic                     CPU_HALTED
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic rcr_op_e decode(input logic [15:0] w);
    rcr_op_e o;
    casez (w)
      16'h9508:              o = OP_RET;
      16'h9518:              o = OP_RET_INT;
      16'h9588:              o = OP_SLEEP;
      16'h9478:              o = OP_SEI;
      16'h94f8:              o = OP_CLI;
      16'b0000_11??_????_????: o = OP_ADD;
      16'b0001_11??_????_????: o = OP_ADC;
      16'b0001_10??_????_????: o = OP_SUB;
      16'b0000_10??_????_????: o = OP_SBC;
      16'b0001_01??_????_????: o = OP_CP;
      16'b0010_00??_????_????: o = OP_AND;
      16'b0010_10??_????_????: o = OP_OR;
      16'b0010_01??_????_????: o = OP_EOR;
      16'b0010_11??_????_????: o = OP_MOV;
      16'b0011_????_????_????: o = OP_CMP_IMM;
      16'b0100_????_????_????: o = OP_SUB_CARRY_IMM;
      16'b0101_????_????_????: o = OP_SUB_IMM;
      16'b0110_????_????_????: o = OP_OR_IMM;
      16'b0111_????_????_????: o = OP_AND_IMM;
      16'b1110_????_????_????: o = OP_LOAD_IMM;
      16'b1100_????_????_????: o = OP_REL_JUMP;
      16'b1101_????_????_????: o = OP_REL_CALL;
      16'b1001_010?_????_0000: o = OP_COM;
      16'b1001_010?_????_0001: o = OP_NEG;
      16'b1001_010?_????_0011: o = OP_INC;
      16'b1001_010?_????_1010: o = OP_DEC;
      16'b1001_010?_????_0110: o = OP_LSR;
      16'b1011_0???_????_????: o = OP_IN;
      16'b1011_1???_????_????: o = OP_OUT;
      16'b1000_000?_????_0000: o = OP_LD_PTR;
      16'b1000_001?_????_0000: o = OP_ST_PTR;
      default:               o = OP_NOP;
    endcase
    return o;
  endfunction : decode

  function automatic rcr_alu_s alu(input rcr_op_e o, input logic [7:0] a,
                                   input logic [7:0] b, input logic cin);
    rcr_alu_s r;
    logic [8:0] s;
    logic       sub;
    s   = 9'h000;
    sub = 1'b0;
    case (o)
      OP_ADD:           s = {1'b0, a} + {1'b0, b};
      OP_ADC:           s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      OP_SUB, OP_CP, OP_SUB_IMM, OP_CMP_IMM:
      begin
        s   = {1'b0, a} - {1'b0, b};
        sub = 1'b1;
      end
      OP_SBC, OP_SUB_CARRY_IMM:
      begin
        s   = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        sub = 1'b1;
      end
      OP_AND, OP_AND_IMM: s = {1'b0, a & b};
      OP_OR, OP_OR_IMM:   s = {1'b0, a | b};
      OP_EOR:           s = {1'b0, a ^ b};
      OP_MOV, OP_LOAD_IMM: s = {1'b0, b};
      OP_COM:           s = {1'b1, ~a};
      OP_NEG:           s = 9'h000 - {1'b0, a};
      OP_INC:           s = {cin, a + 8'h01};
      OP_DEC:           s = {cin, a - 8'h01};
      OP_LSR:           s = {a[0], 1'b0, a[7:1]};
      default:          s = {1'b0, a};
    endcase
    r.res = s[7:0];
    r.c   = s[8];
    r.z   = (s[7:0] == 8'h00);
    r.n   = s[7];
    r.v   = sub ? ((a[7] != b[7]) && (s[7] != a[7]))
                : ((a[7] == b[7]) && (s[7] != a[7]) && (o == OP_ADD || o == OP_ADC));
    return r;
  endfunction : alu

  function automatic logic [`RCR_PC_W-1:0] vector_of(input logic [`RCR_NIRQ-1:0] p);
    logic [`RCR_PC_W-1:0] v;
    v = `RCR_RESET_PC;
    for (int i = `RCR_NIRQ - 1; i >= 0; i--)
    begin
      if (p[i])
        v = `RCR_PC_W'(i + 1);
    end
    return v;
  endfunction : vector_of

  // ****************************************
  // State
  // ****************************************
  logic [7:0]            rf_q   [0:`RCR_NREG-1];
  logic [`RCR_PC_W-1:0]  stk_q  [0:`RCR_STK_DEPTH-1];
  logic [`RCR_PC_W-1:0]  pc_q;
  logic [15:0]           ir_q;
  logic                  ir_valid_q;
  logic [7:0]            core_status_register_q;
  rcr_state_e            state_q;
  rcr_io_wr_s            io_wr_q;
  logic [`RCR_NIRQ-1:0]  irq_ack_q;
  logic                  rc_sel_q;

  // ****************************************
  // Execute stage
  // ****************************************
  rcr_op_e               op;
  rcr_alu_s              res;
  logic                  exec;
  logic                  take_irq;
  logic [4:0]            d_idx;
  logic [4:0]            r_idx;
  logic [4:0]            up_idx;
  logic [7:0]            imm;
  logic [7:0]            opa;
  logic [7:0]            opb;
  logic [5:0]            io_addr;
  logic [7:0]            indirect_pointer_reg;
  logic                  ptr_ok;
  logic                  is_imm;
  logic                  wr_en;
  logic [4:0]            wr_idx;
  logic [7:0]            wr_data;
  logic                  flags_en;
  logic                  redirect;
  logic [`RCR_PC_W-1:0]  target;
  logic                  push;
  logic                  pop;
  logic [`RCR_PC_W-1:0]  push_val;

  assign exec     = ir_valid_q && (state_q == ST_RUN);
  assign take_irq = exec && core_status_register_q[`RCR_BIT_I] && (|IRQ_PEND);
  assign op       = (exec && !take_irq) ? decode(ir_q) : OP_NOP;
  assign d_idx    = ir_q[8:4];
  assign r_idx    = {ir_q[9], ir_q[3:0]};
  assign up_idx   = `RCR_UPPER_OFS + {1'b0, ir_q[7:4]};
  assign imm      = {ir_q[11:8], ir_q[3:0]};
  assign io_addr  = {ir_q[10:9], ir_q[3:0]};
  assign indirect_pointer_reg = rf_q[`RCR_PTR_IDX];
  assign ptr_ok   = (indirect_pointer_reg[7:5] == 3'h0);
  assign is_imm   = (op == OP_SUB_IMM) || (op == OP_SUB_CARRY_IMM) || (op == OP_CMP_IMM)
                 || (op == OP_AND_IMM) || (op == OP_OR_IMM) || (op == OP_LOAD_IMM);
  assign opa      = is_imm ? rf_q[up_idx] : rf_q[d_idx];
  assign opb      = is_imm ? imm : rf_q[r_idx];
  assign res      = alu(op, opa, opb, core_status_register_q[`RCR_BIT_C]);

  assign IO_RD_ADDR = io_addr;
  assign IO_RE      = (op == OP_IN) && (io_addr != `RCR_IO_STATUS);

  always_comb
  begin
    wr_en    = 1'b0;
    wr_idx   = is_imm ? up_idx : d_idx;
    wr_data  = res.res;
    flags_en = 1'b0;
    redirect = 1'b0;
    target   = pc_q;
    push     = 1'b0;
    pop      = 1'b0;
    push_val = pc_q;
    if (take_irq)
    begin
      redirect = 1'b1;
      target   = vector_of(IRQ_PEND);
      push     = 1'b1;
      push_val = pc_q - `RCR_PC_W'(1);
    end
    unique case (op)
      OP_NOP, OP_SEI, OP_CLI, OP_OUT, OP_ST_PTR:
        wr_en = 1'b0;
      OP_CP, OP_CMP_IMM:
        flags_en = 1'b1;
      OP_MOV, OP_LOAD_IMM:
        wr_en = 1'b1;
      OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR, OP_SUB_IMM,
      OP_SUB_CARRY_IMM, OP_AND_IMM, OP_OR_IMM, OP_COM, OP_NEG, OP_INC, OP_DEC, OP_LSR:
      begin
        wr_en    = 1'b1;
        flags_en = 1'b1;
      end
      OP_IN:
      begin
        wr_en   = 1'b1;
        wr_data = (io_addr == `RCR_IO_STATUS) ? core_status_register_q : IO_RDATA;
      end
      OP_LD_PTR:
      begin
        wr_en   = 1'b1;
        wr_data = ptr_ok ? rf_q[indirect_pointer_reg[4:0]] : 8'h00;
      end
      OP_REL_JUMP, OP_REL_CALL:
      begin
        redirect = 1'b1;
        target   = pc_q + ir_q[`RCR_PC_W-1:0];
        push     = (op == OP_REL_CALL);
      end
      OP_RET, OP_RET_INT:
      begin
        redirect = 1'b1;
        target   = stk_q[0];
        pop      = 1'b1;
      end
      OP_SLEEP:
        redirect = 1'b0;
    endcase
  end

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
    begin
      for (int i = 0; i < `RCR_NREG; i++)
        rf_q[i] <= 8'h00;
    end
    else if (wr_en)
      rf_q[wr_idx] <= wr_data;
    else if (op == OP_ST_PTR && ptr_ok)
      rf_q[indirect_pointer_reg[4:0]] <= rf_q[d_idx];
  end

  // ****************************************
  // Status register
  // ****************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      core_status_register_q <= `RCR_STATUS_RST;
    else if (take_irq)
      core_status_register_q[`RCR_BIT_I] <= 1'b0;
    else if (op == OP_RET_INT || op == OP_SEI)
      core_status_register_q[`RCR_BIT_I] <= 1'b1;
    else if (op == OP_CLI)
      core_status_register_q[`RCR_BIT_I] <= 1'b0;
    else if (op == OP_OUT && io_addr == `RCR_IO_STATUS)
      core_status_register_q <= rf_q[d_idx];
    else if (flags_en)
    begin
      core_status_register_q[`RCR_BIT_C] <= res.c;
      core_status_register_q[`RCR_BIT_Z] <= res.z;
      core_status_register_q[`RCR_BIT_N] <= res.n;
      core_status_register_q[`RCR_BIT_V] <= res.v;
    end
  end

  // ****************************************
  // Hardware return stack
  // ****************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
    begin
      for (int i = 0; i < `RCR_STK_DEPTH; i++)
        stk_q[i] <= `RCR_RESET_PC;
    end
    else if (push)
    begin
      stk_q[0] <= push_val;
      for (int i = 1; i < `RCR_STK_DEPTH; i++)
        stk_q[i] <= stk_q[i-1];
    end
    else if (pop)
    begin
      for (int i = 0; i < `RCR_STK_DEPTH - 1; i++)
        stk_q[i] <= stk_q[i+1];
    end
  end

  // ****************************************
  // Fetch stage
  // ****************************************
  assign PROG_ADDR = pc_q;

  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
    begin
      pc_q       <= `RCR_RESET_PC;
      ir_q       <= 16'h0000;
      ir_valid_q <= 1'b0;
    end
    else if (state_q != ST_RUN || op == OP_SLEEP)
      ir_valid_q <= 1'b0;
    else if (redirect)
    begin
      pc_q       <= target;
      ir_valid_q <= 1'b0;
    end
    else
    begin
      pc_q       <= pc_q + `RCR_PC_W'(1);
      ir_q       <= PROG_DATA;
      ir_valid_q <= 1'b1;
    end
  end

  // ****************************************
  // Sleep control
  // ****************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      state_q <= ST_RUN;
    else
    begin
      unique case (state_q)
        ST_RUN:
        begin
          if (op == OP_SLEEP && SLEEP_EN)
            state_q <= SLEEP_PDOWN ? ST_PDOWN : ST_IDLE;
        end
        ST_IDLE:
        begin
          if ((|IRQ_PEND) || EXT_WAKE)
            state_q <= ST_RUN;
        end
        ST_PDOWN:
        begin
          if (EXT_WAKE)
            state_q <= ST_RUN;
        end
        default:
          state_q <= ST_RUN;
      endcase
    end
  end

  assign OSC_STOP   = (state_q == ST_PDOWN);
  assign CPU_HALTED = (state_q != ST_RUN);

  // ****************************************
  // I/O writes and interrupt acknowledge
  // ****************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      io_wr_q <= '0;
    else
    begin
      io_wr_q.we   <= (op == OP_OUT) && (io_addr != `RCR_IO_STATUS);
      io_wr_q.addr <= io_addr;
      io_wr_q.data <= rf_q[d_idx];
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      irq_ack_q <= '0;
    else if (take_irq)
      irq_ack_q <= IRQ_PEND & ~(IRQ_PEND - `RCR_NIRQ'(1));
    else
      irq_ack_q <= '0;
  end

  assign IO_WR   = io_wr_q;
  assign IRQ_ACK = irq_ack_q;

  // ****************************************
  // Clock source select
  // ****************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      rc_sel_q <= 1'b0;
    else
      rc_sel_q <= !RC_CLOCK_SELECT_FUSE;
  end

  assign RC_CLK_SEL = rc_sel_q;

endmodule : rcr_core

/* File: bench/rcr_core_assertions.sv */
// Port checker of the execution core
`timescale 1ns/1ps
module rcr_core_assertions
  import rcr_pkg::*;
(
  input wire logic       CORE_CLK,
  input wire logic       NRST,
  input wire logic [8:0] PROG_ADDR,
  input wire logic       IO_RE,
  input wire rcr_io_wr_s IO_WR,
  input wire logic [3:0] IRQ_PEND,
  input wire logic [3:0] IRQ_ACK,
  input wire logic       EXT_WAKE,
  input wire logic       RC_CLOCK_SELECT_FUSE,
  input wire logic       RC_CLK_SEL,
  input wire logic       OSC_STOP,
  input wire logic       CPU_HALTED
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  property p_reset_fetch;
    $rose(NRST) |-> PROG_ADDR == 9'h000 ##1 PROG_ADDR == 9'h001;
  endproperty
  a_reset_fetch: assert property (p_reset_fetch)
    else $error("fetch start after reset wrong");

  property p_halt_freeze;
    CPU_HALTED && $past(CPU_HALTED) |-> $stable(PROG_ADDR) && !IO_RE && !IO_WR.we;
  endproperty
  a_halt_freeze: assert property (p_halt_freeze)
    else $error("activity while halted");

  property p_io_status;
    IO_WR.we |-> IO_WR.addr != 6'h3f;
  endproperty
  a_io_status: assert property (p_io_status)
    else $error("status address seen on io write");

  property p_ack_prio;
    IRQ_ACK != 4'h0 |-> $onehot(IRQ_ACK) && ($past(IRQ_PEND) & IRQ_ACK) != 4'h0
      && ($past(IRQ_PEND) & (IRQ_ACK - 4'h1)) == 4'h0;
  endproperty
  a_ack_prio: assert property (p_ack_prio)
    else $error("interrupt priority wrong");

  property p_ack_vector;
    IRQ_ACK != 4'h0 |-> PROG_ADDR == (IRQ_ACK[0] ? 9'h001 : IRQ_ACK[1] ? 9'h002 :
      IRQ_ACK[2] ? 9'h003 : 9'h004);
  endproperty
  a_ack_vector: assert property (p_ack_vector)
    else $error("interrupt vector address wrong");

  property p_ack_gap;
    IRQ_ACK != 4'h0 |=> (IRQ_ACK == 4'h0) [*3];
  endproperty
  a_ack_gap: assert property (p_ack_gap)
    else $error("interrupt taken while disabled");

  property p_pdown_hold;
    OSC_STOP && !EXT_WAKE |=> OSC_STOP && CPU_HALTED;
  endproperty
  a_pdown_hold: assert property (p_pdown_hold)
    else $error("power-down left without wake");

  property p_wake;
    CPU_HALTED && EXT_WAKE |-> ##[1:2] !CPU_HALTED;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on external request");

  property p_rc_sel;
    $past(NRST) |-> RC_CLK_SEL == !$past(RC_CLOCK_SELECT_FUSE);
  endproperty
  a_rc_sel: assert property (p_rc_sel)
    else $error("clock source select wrong");

  c_irq: cover property (IRQ_ACK == 4'h8);
  c_pdown: cover property (OSC_STOP ##1 !OSC_STOP);
  c_out: cover property (IO_WR.we);
endmodule : rcr_core_assertions

bind rcr_core rcr_core_assertions u_chk (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .PROG_ADDR(PROG_ADDR), .IO_RE(IO_RE),
  .IO_WR(IO_WR), .IRQ_PEND(IRQ_PEND), .IRQ_ACK(IRQ_ACK), .EXT_WAKE(EXT_WAKE),
  .RC_CLOCK_SELECT_FUSE(RC_CLOCK_SELECT_FUSE), .RC_CLK_SEL(RC_CLK_SEL),
  .OSC_STOP(OSC_STOP), .CPU_HALTED(CPU_HALTED));

/* File: bench/rcr_prog_model.sv */
// Program word store and I/O space model
`timescale 1ns/1ps
module rcr_prog_model
  import rcr_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  input  wire logic [8:0]  PROG_ADDR,
  output      logic [15:0] PROG_DATA,
  input  wire logic [5:0]  IO_RD_ADDR,
  input  wire logic        IO_RE,
  output      logic [7:0]  IO_RDATA,
  input  wire rcr_io_wr_s  IO_WR
);
  // ********
  // Storage
  // ********
  logic [15:0] mem [0:511];
  logic [13:0] wr_log_q [0:63];
  int          wr_cnt_q;
  logic [7:0]  rd_val;

  assign PROG_DATA = mem[PROG_ADDR];
  assign rd_val    = {IO_RD_ADDR, 2'b01} ^ 8'ha5;
  // Unselected bus never shows the value
  assign IO_RDATA  = IO_RE ? rd_val : ~rd_val;

  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      wr_cnt_q <= 0;
    else if (IO_WR.we && wr_cnt_q < 64)
    begin
      wr_log_q[wr_cnt_q] <= {IO_WR.addr, IO_WR.data};
      wr_cnt_q           <= wr_cnt_q + 1;
    end
  end
endmodule : rcr_prog_model

/* File: bench/tb_top.sv */
// Self-checking bench of the execution core
`timescale 1ns/1ps
module tb_top
  import rcr_pkg::*;
;
  // ********
  // Signals
  // ********
  logic        core_clk;
  logic        nrst;
  logic [3:0]  irq_pend;
  logic        ext_wake;
  logic        sleep_en;
  logic        sleep_pdown;
  logic        fuse;
  logic [8:0]  prog_addr;
  logic [15:0] prog_data;
  logic [5:0]  io_rd_addr;
  logic        io_re;
  logic [7:0]  io_rdata;
  rcr_io_wr_s  io_wr;
  logic [3:0]  irq_ack;
  logic        rc_clk_sel;
  logic        osc_stop;
  logic        cpu_halted;
  int          failures;
  int          num_checks;
  logic [13:0] exp_q [$];

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  rcr_core u_dut (
    .CORE_CLK(core_clk), .NRST(nrst), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
    .IO_RD_ADDR(io_rd_addr), .IO_RE(io_re), .IO_RDATA(io_rdata), .IO_WR(io_wr),
    .IRQ_PEND(irq_pend), .IRQ_ACK(irq_ack), .EXT_WAKE(ext_wake), .SLEEP_EN(sleep_en),
    .SLEEP_PDOWN(sleep_pdown), .RC_CLOCK_SELECT_FUSE(fuse), .RC_CLK_SEL(rc_clk_sel),
    .OSC_STOP(osc_stop), .CPU_HALTED(cpu_halted));

  rcr_prog_model u_mem (
    .CORE_CLK(core_clk), .NRST(nrst), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
    .IO_RD_ADDR(io_rd_addr), .IO_RE(io_re), .IO_RDATA(io_rdata), .IO_WR(io_wr));

  // Interrupt source drops its request once served
  always @(posedge core_clk)
  begin
    #1;
    if (irq_ack != 4'h0)
      irq_pend = irq_pend & ~irq_ack;
  end

  // ********
  // Helpers
  // ********
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [15:0] f_imm(logic [3:0] op, int d, logic [7:0] k);
    return {op, k[7:4], d[3:0], k[3:0]};
  endfunction : f_imm

  function automatic logic [15:0] f_io(logic o, int a, int r);
    return {4'hb, o, a[5:4], r[4:0], a[3:0]};
  endfunction : f_io

  task automatic prog_clear();
    nrst = 1'b0;
    for (int i = 0; i < 512; i++)
      u_mem.mem[i] = 16'h0000;
  endtask : prog_clear

  task automatic do_reset(input logic f);
    nrst = 1'b0;
    fuse = f;
    tick(20);
    nrst = 1'b1;
  endtask : do_reset

  task automatic bound_hit(input string what);
    failures++;
    $display("[ERR] %s expected done seen timeout", what);
    finish_test();
  endtask : bound_hit

  task automatic check_io(input string what);
    int n;
    n = 0;
    while (u_mem.wr_cnt_q < exp_q.size() && n < 400)
    begin
      tick(1);
      n++;
    end
    if (u_mem.wr_cnt_q < exp_q.size())
      bound_hit(what);
    foreach (exp_q[i])
      chk(what, 16'(exp_q[i]), 16'(u_mem.wr_log_q[i]));
    exp_q.delete();
  endtask : check_io

  task automatic wait_halt(input logic v);
    int n;
    n = 0;
    while (cpu_halted !== v && n < 50)
    begin
      tick(1);
      n++;
    end
    if (cpu_halted !== v)
      bound_hit("halt wait");
  endtask : wait_halt

  // ********
  // Scenarios
  // ********
  task automatic t_reset_fetch();
    prog_clear();
    do_reset(1'b1);
    chk("pc after reset", 16'h0000, 16'(prog_addr));
    for (int k = 1; k <= 4; k++)
    begin
      tick(1);
      chk("pc sequence", 16'(k), 16'(prog_addr));
    end
    chk("rc select", 16'h0000, 16'(rc_clk_sel));
    $display("test reset_fetch done");
  endtask : t_reset_fetch

  task automatic t_alu_regs();
    prog_clear();
    u_mem.mem[0]  = f_imm(4'he, 16, 8'h12);
    u_mem.mem[1]  = f_imm(4'he, 31, 8'h34);
    u_mem.mem[2]  = {6'h0b, 1'b1, 5'd0, 4'h0};
    u_mem.mem[3]  = {6'h03, 1'b1, 5'd0, 4'hf};
    u_mem.mem[4]  = f_io(1'b1, 16, 0);
    u_mem.mem[5]  = f_imm(4'h5, 31, 8'h01);
    u_mem.mem[6]  = f_io(1'b1, 17, 31);
    u_mem.mem[7]  = f_io(1'b0, 7, 5);
    u_mem.mem[8]  = f_imm(4'he, 30, 8'h05);
    u_mem.mem[9]  = {6'h20, 1'b0, 5'd1, 4'h0};
    u_mem.mem[10] = f_io(1'b1, 18, 1);
    u_mem.mem[11] = f_imm(4'h7, 16, 8'h0f);
    u_mem.mem[12] = f_imm(4'h6, 16, 8'h30);
    u_mem.mem[13] = f_imm(4'h3, 16, 8'h32);
    u_mem.mem[14] = f_imm(4'h4, 16, 8'h02);
    u_mem.mem[15] = f_io(1'b1, 19, 16);
    u_mem.mem[16] = {6'h20, 1'b1, 5'd16, 4'h0};
    u_mem.mem[17] = f_io(1'b1, 20, 5);
    u_mem.mem[18] = {6'h09, 1'b1, 5'd0, 4'hf};
    u_mem.mem[19] = {7'h4a, 5'd0, 4'ha};
    u_mem.mem[20] = {7'h4a, 5'd0, 4'h6};
    u_mem.mem[21] = {7'h4a, 5'd0, 4'h0};
    u_mem.mem[22] = {6'h07, 1'b1, 5'd0, 4'hf};
    u_mem.mem[23] = f_io(1'b1, 21, 0);
    u_mem.mem[24] = f_io(1'b0, 63, 2);
    u_mem.mem[25] = f_io(1'b1, 22, 2);
    u_mem.mem[26] = {4'hc, 12'hfff};
    do_reset(1'b1);
    // Read value 0xb8 is the model's answer at address 0x07
    // Status after add with carry: only N set
    exp_q = '{{6'h10, 8'h46}, {6'h11, 8'h33}, {6'h12, 8'hb8}, {6'h13, 8'h30},
              {6'h14, 8'h30}, {6'h15, 8'hf9}, {6'h16, 8'h04}};
    check_io("alu results");
    $display("test alu_regs done");
  endtask : t_alu_regs

  task automatic t_call_stack();
    prog_clear();
    u_mem.mem[0]   = {4'hc, 12'd507};
    u_mem.mem[508] = {4'hd, 12'd13};
    u_mem.mem[509] = f_io(1'b1, 62, 20);
    for (int i = 1; i <= 3; i++)
    begin
      u_mem.mem[10 * i]     = {4'hd, 12'd9};
      u_mem.mem[10 * i + 2] = 16'h9508;
    end
    u_mem.mem[11] = {7'h4a, 5'd20, 4'h3};
    u_mem.mem[12] = f_io(1'b1, 33, 20);
    u_mem.mem[13] = 16'h9508;
    u_mem.mem[21] = f_io(1'b1, 34, 20);
    u_mem.mem[31] = f_io(1'b1, 35, 20);
    u_mem.mem[40] = 16'h9508;
    do_reset(1'b1);
    exp_q = '{{6'h23, 8'h00}, {6'h22, 8'h00}, {6'h21, 8'h01}, {6'h21, 8'h02}};
    check_io("return order");
    $display("test call_stack done");
  endtask : t_call_stack

  task automatic t_irq();
    prog_clear();
    u_mem.mem[0] = {4'hc, 12'd7};
    for (int i = 1; i <= 4; i++)
    begin
      u_mem.mem[i]         = {4'hc, 12'(15 + i)};
      u_mem.mem[16 + 2 * i] = f_io(1'b1, 48 + i, 16);
      u_mem.mem[17 + 2 * i] = 16'h9518;
    end
    u_mem.mem[8]  = f_imm(4'he, 16, 8'h5a);
    u_mem.mem[9]  = 16'h9478;
    u_mem.mem[10] = {4'hc, 12'hfff};
    do_reset(1'b1);
    irq_pend = 4'hf;
    exp_q = '{{6'h31, 8'h5a}, {6'h32, 8'h5a}, {6'h33, 8'h5a}, {6'h34, 8'h5a}};
    check_io("interrupt order");
    $display("test irq done");
  endtask : t_irq

  task automatic t_sleep();
    prog_clear();
    u_mem.mem[0] = f_imm(4'he, 16, 8'h77);
    u_mem.mem[1] = 16'h9588;
    u_mem.mem[2] = f_io(1'b1, 21, 16);
    u_mem.mem[3] = 16'h9588;
    u_mem.mem[4] = f_io(1'b1, 22, 16);
    u_mem.mem[5] = {4'hc, 12'hfff};
    sleep_en = 1'b1;
    sleep_pdown = 1'b0;
    do_reset(1'b0);
    wait_halt(1'b1);
    tick(10);
    chk("idle halt", 16'h0001, 16'(cpu_halted));
    chk("idle osc", 16'h0000, 16'(osc_stop));
    chk("idle writes", 16'h0000, 16'(u_mem.wr_cnt_q));
    chk("rc select", 16'h0001, 16'(rc_clk_sel));
    sleep_pdown = 1'b1;
    ext_wake = 1'b1;
    tick(1);
    ext_wake = 1'b0;
    wait_halt(1'b0);
    wait_halt(1'b1);
    chk("pdown osc", 16'h0001, 16'(osc_stop));
    irq_pend = 4'h1;
    tick(5);
    chk("pdown hold", 16'h0001, 16'(cpu_halted));
    irq_pend = 4'h0;
    ext_wake = 1'b1;
    tick(1);
    ext_wake = 1'b0;
    exp_q = '{{6'h15, 8'h77}, {6'h16, 8'h77}};
    check_io("sleep resume");
    sleep_en = 1'b0;
    $display("test sleep done");
  endtask : t_sleep

  initial
  begin
    failures = 0;
    num_checks = 0;
    nrst = 1'b0;
    fuse = 1'b1;
    irq_pend = 4'h0;
    ext_wake = 1'b0;
    sleep_en = 1'b0;
    sleep_pdown = 1'b0;
    t_reset_fetch();
    t_alu_regs();
    t_call_stack();
    t_irq();
    t_sleep();
    finish_test();
  end
endmodule : tb_top
